// ---- hw/wdw_watchdog.sv ----
// windowed watchdog timer with prescaler, postscaler and power-save handling
`timescale 1ns/1ps
// Contract
// - clock from rc oscillator, enabled with watchdog
// - prescaler divides by 32 or 128
// - prescaled period 1 ms or 4 ms
// - 4-bit postscaler, sixteen ratios 1 to 32768
// - clear counters on reset and clock switch
// - clear counters entering and leaving power save
// - kick clears counter, prescaler and postscaler
// - keeps counting in sleep and idle
// - timeout wakes core; sleep/idle bits sticky
// - timeout flag bit 4, software clears only
// - force-on bit runs watchdog unconditionally
// - software enable bit 5, cleared on reset
// - window mode: early kick causes reset
// - prescale select 1 gives 128, 0 gives 32
// - postscale code n gives ratio 2 to n
// - window disable 1 non-window, 0 window
module wdw_watchdog import wdw_pkg::*; #(
   parameter int RC_DIV = RC_TICK_CYCLES
) (
   // clock and reset
   input wire logic CLOCK_I,
   input wire logic NRST_I,
   // configuration and core events
   input wire wdw_cfg_t CFG_I,
   input wire wdw_evt_t EVT_I,
   // reset control word write
   input wire logic RCW_WR_I,
   input wire logic [RCW_W-1:0] RCW_WDATA_I,
   // status
   output logic [RCW_W-1:0] RCW_O,
   output logic RC_OSC_EN_O,
   output logic RUNNING_O,
   output logic WINDOW_OPEN_O,
   // actions on the core
   output logic WAKE_O,
   output logic WDOG_RESET_O
);

   // elaboration checks
   if (RC_DIV < 2 || RC_DIV > (1 << RC_CNT_W)) begin : g_bad_div
      $error("wdw_watchdog: rc divider out of range");
   end
   if (PRE_DIV_SHORT * RC_PERIOD_NS != PERIOD_SHORT_NS) begin : g_bad_short
      $error("wdw_watchdog: short prescaled period mismatch");
   end
   if (PRE_DIV_LONG * RC_PERIOD_NS != PERIOD_LONG_NS) begin : g_bad_long
      $error("wdw_watchdog: long prescaled period mismatch");
   end
   // window shifts must match the prescaler ratios
   if ((1 << PRE_SHIFT_SHORT) != PRE_DIV_SHORT || (1 << PRE_SHIFT_LONG) != PRE_DIV_LONG) begin : g_bad_shift
      $error("wdw_watchdog: prescaler shift mismatch");
   end
   // postscaler counter must hold the largest terminal count
   if (POST_CNT_W < (1 << POST_CODE_W) - 1) begin : g_bad_post
      $error("wdw_watchdog: postscaler counter too narrow");
   end
   // prescaler counter must hold the long terminal count
   if ((1 << PRE_CNT_W) < PRE_DIV_LONG) begin : g_bad_pre
      $error("wdw_watchdog: prescaler counter too narrow");
   end
   // window arithmetic must hold four times the longest period
   if (POS_W < POST_CNT_W + PRE_SHIFT_LONG + WIN_DEN_SHIFT + 1) begin : g_bad_pos
      $error("wdw_watchdog: window width too narrow");
   end

   localparam logic [RC_CNT_W-1:0] RC_LIMIT = RC_CNT_W'(RC_DIV - 1);
   localparam logic [PRE_CNT_W-1:0] PRE_LIMIT_SHORT = PRE_CNT_W'(PRE_DIV_SHORT - 1);
   localparam logic [PRE_CNT_W-1:0] PRE_LIMIT_LONG = PRE_CNT_W'(PRE_DIV_LONG - 1);

   // state
   wdw_pwr_t pwr_reg;
   wdw_pwr_t pwr_next;
   logic sw_en_reg;
   logic sw_en_next;
   logic timeout_reg;
   logic timeout_next;
   logic sleep_reg;
   logic sleep_next;
   logic idle_reg;
   logic idle_next;
   logic wdog_reset_reg;
   logic wdog_reset_next;
   logic wake_reg;
   logic wake_next;

   // datapath
   logic enabled;
   logic in_run;
   logic cnt_clr;
   logic rc_tick;
   logic pre_wrap;
   logic post_wrap;
   logic timeout_evt;
   logic kick_run;
   logic kick_early;
   logic window_mode;
   logic window_open;
   logic leave_pwr;
   logic enter_pwr;
   logic [PRE_CNT_W-1:0] pre_cnt;
   logic [PRE_CNT_W-1:0] pre_limit;
   logic [POST_CNT_W-1:0] post_cnt;
   logic [POST_CNT_W-1:0] post_limit;
   logic [POS_W-1:0] pos;
   logic [POS_W-1:0] total;

   // enable and rc oscillator request
   always_comb begin
      enabled = CFG_I.hw_force_on_bit || sw_en_reg;
      in_run = (pwr_reg == PWR_RUN);
      window_mode = !CFG_I.window_disable_bit;
   end
   assign RC_OSC_EN_O = enabled;
   assign RUNNING_O = enabled;

   // power-save transitions seen this cycle
   always_comb begin
      enter_pwr = in_run && (EVT_I.enter_sleep || EVT_I.enter_idle);
      leave_pwr = !in_run && (EVT_I.wake_other || timeout_evt);
   end

   // kicks count only during normal execution
   always_comb begin
      kick_run = in_run && EVT_I.kick_instruction;
      kick_early = kick_run && enabled && window_mode && !window_open;
   end

   // one clear for rc divider, prescaler and postscaler
   always_comb begin
      cnt_clr = wdog_reset_reg
         || EVT_I.clk_switch_done
         || enter_pwr
         // a timeout wake already wraps all three to zero; only an outside
         // wake clears here, which keeps the wrap pulses out of the clear
         || (!in_run && EVT_I.wake_other)
         || (kick_run && !kick_early)
         || !enabled;
   end

   // rc time base derived from the system clock
   wdw_divider #(
      .W(RC_CNT_W)
   ) u_rc (
      .clk_i(CLOCK_I),
      .rst_n_i(NRST_I),
      .clr_i(cnt_clr),
      .run_i(enabled),
      .limit_i(RC_LIMIT),
      .cnt_o(),
      .wrap_o(rc_tick)
   );

   // prescaler ratio
   always_comb begin
      pre_limit = CFG_I.prescale_ratio_select ? PRE_LIMIT_LONG : PRE_LIMIT_SHORT;
   end

   // prescaler, divide by 32 or 128
   wdw_divider #(
      .W(PRE_CNT_W)
   ) u_pre (
      .clk_i(CLOCK_I),
      .rst_n_i(NRST_I),
      .clr_i(cnt_clr),
      .run_i(rc_tick),
      .limit_i(pre_limit),
      .cnt_o(pre_cnt),
      .wrap_o(pre_wrap)
   );

   // postscaler terminal count is two to the code, less one
   always_comb begin
      post_limit = POST_CNT_W'((32'h1 << CFG_I.postscale_ratio_select) - 32'h1);
   end

   // postscaler
   wdw_divider #(
      .W(POST_CNT_W)
   ) u_post (
      .clk_i(CLOCK_I),
      .rst_n_i(NRST_I),
      .clr_i(cnt_clr),
      .run_i(pre_wrap),
      .limit_i(post_limit),
      .cnt_o(post_cnt),
      .wrap_o(post_wrap)
   );

   // timeout in any power state
   assign timeout_evt = post_wrap;

   // window position in prescaler steps against the whole period
   always_comb begin
      if (CFG_I.prescale_ratio_select) begin
         pos = (POS_W'(post_cnt) << PRE_SHIFT_LONG) + POS_W'(pre_cnt);
         total = POS_W'({1'b0, post_limit} + 16'h1) << PRE_SHIFT_LONG;
      end else begin
         pos = (POS_W'(post_cnt) << PRE_SHIFT_SHORT) + POS_W'(pre_cnt);
         total = POS_W'({1'b0, post_limit} + 16'h1) << PRE_SHIFT_SHORT;
      end
      // open in the final quarter: 4*pos >= 3*total
      window_open = (pos << WIN_DEN_SHIFT) >= POS_W'(total * POS_W'(WIN_NUM));
   end
   assign WINDOW_OPEN_O = window_open || !window_mode;

   // power state machine
   always_comb begin
      pwr_next = pwr_reg;
      case (pwr_reg)
         PWR_RUN: begin
            if (EVT_I.enter_sleep) begin
               pwr_next = PWR_SLEEP;
            end else if (EVT_I.enter_idle) begin
               pwr_next = PWR_IDLE;
            end
         end
         PWR_SLEEP, PWR_IDLE: begin
            if (leave_pwr) begin
               pwr_next = PWR_RUN;
            end
         end
         default: begin
            pwr_next = PWR_RUN;
         end
      endcase
      if (wdog_reset_reg) begin
         pwr_next = PWR_RUN;
      end
   end

   // reset and wake requests
   always_comb begin
      wdog_reset_next = (in_run && timeout_evt) || kick_early;
      wake_next = !in_run && timeout_evt;
   end

   // software enable, cleared by any device reset
   always_comb begin
      sw_en_next = sw_en_reg;
      if (RCW_WR_I) begin
         sw_en_next = RCW_WDATA_I[RCW_SWEN_BIT];
      end
      if (wdog_reset_reg) begin
         sw_en_next = 1'b0;
      end
   end

   // sticky flags: software writes zero to clear, a set wins
   always_comb begin
      timeout_next = timeout_reg;
      sleep_next = sleep_reg;
      idle_next = idle_reg;
      if (RCW_WR_I) begin
         timeout_next = timeout_reg && RCW_WDATA_I[RCW_TIMEOUT_BIT];
         sleep_next = sleep_reg && RCW_WDATA_I[RCW_SLEEP_BIT];
         idle_next = idle_reg && RCW_WDATA_I[RCW_IDLE_BIT];
      end
      if (timeout_evt || kick_early) begin
         timeout_next = 1'b1;
      end
      // sleep wins over idle when both arrive together
      if (in_run && EVT_I.enter_sleep) begin
         sleep_next = 1'b1;
      end else if (in_run && EVT_I.enter_idle) begin
         idle_next = 1'b1;
      end
   end

   // state registers
   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         pwr_reg <= PWR_RUN;
         sw_en_reg <= RCW_RESET[RCW_SWEN_BIT];
         timeout_reg <= RCW_RESET[RCW_TIMEOUT_BIT];
         sleep_reg <= RCW_RESET[RCW_SLEEP_BIT];
         idle_reg <= RCW_RESET[RCW_IDLE_BIT];
         wdog_reset_reg <= 1'b0;
         wake_reg <= 1'b0;
      end else begin
         pwr_reg <= pwr_next;
         sw_en_reg <= sw_en_next;
         timeout_reg <= timeout_next;
         sleep_reg <= sleep_next;
         idle_reg <= idle_next;
         wdog_reset_reg <= wdog_reset_next;
         wake_reg <= wake_next;
      end
   end

   // reset control word view, other bits read zero
   always_comb begin
      RCW_O = RCW_RESET;
      RCW_O[RCW_SWEN_BIT] = sw_en_reg;
      RCW_O[RCW_TIMEOUT_BIT] = timeout_reg;
      RCW_O[RCW_SLEEP_BIT] = sleep_reg;
      RCW_O[RCW_IDLE_BIT] = idle_reg;
   end

   assign WAKE_O = wake_reg;
   assign WDOG_RESET_O = wdog_reset_reg;

endmodule

// ---- shared/wdw_pkg.sv ----
// constants and types shared by the windowed watchdog design
package wdw_pkg;

   // system clock and the low-power rc time base
   localparam int CLK_PERIOD_NS = 20;
   localparam int RC_PERIOD_NS = 31250;                   // 32 kHz nominal
   localparam int RC_TICK_CYCLES = RC_PERIOD_NS / CLK_PERIOD_NS;

   // nominal prescaled periods
   localparam int PERIOD_SHORT_NS = 1000000;              // 1 ms
   localparam int PERIOD_LONG_NS = 4000000;               // 4 ms

   // prescaler ratios and their shifts
   localparam int PRE_DIV_SHORT = 32;
   localparam int PRE_DIV_LONG = 128;
   localparam int PRE_SHIFT_SHORT = 5;
   localparam int PRE_SHIFT_LONG = 7;

   // counter widths
   localparam int RC_CNT_W = 11;
   localparam int PRE_CNT_W = 7;
   localparam int POST_CODE_W = 4;
   localparam int POST_CNT_W = 15;
   localparam int POS_W = 25;                              // window arithmetic width

   // window: clears accepted in the final quarter
   localparam int WIN_NUM = 3;
   localparam int WIN_DEN_SHIFT = 2;

   // reset control word layout
   localparam int RCW_W = 8;
   localparam int RCW_IDLE_BIT = 2;
   localparam int RCW_SLEEP_BIT = 3;
   localparam int RCW_TIMEOUT_BIT = 4;
   localparam int RCW_SWEN_BIT = 5;
   localparam logic [RCW_W-1:0] RCW_RESET = 8'h00;

   // watchdog config word, bit 7 down to bit 0
   typedef struct packed {
      logic hw_force_on_bit;                               // bit 7
      logic window_disable_bit;                            // bit 6
      logic reserved;                                      // bit 5
      logic prescale_ratio_select;                         // bit 4
      logic [POST_CODE_W-1:0] postscale_ratio_select;      // bits 3:0
   } wdw_cfg_t;

   // one-cycle events from the core
   typedef struct packed {
      logic kick_instruction;
      logic enter_sleep;
      logic enter_idle;
      logic wake_other;
      logic clk_switch_done;
   } wdw_evt_t;

   // power state
   typedef enum logic [2:0] {
      PWR_RUN = 3'h1,
      PWR_SLEEP = 3'h2,
      PWR_IDLE = 3'h4
   } wdw_pwr_t;

endpackage

// ---- hw/wdw_divider.sv ----
// clearable counting divider with terminal pulse
`timescale 1ns/1ps
module wdw_divider import wdw_pkg::*; #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // control
   input wire logic clr_i,
   input wire logic run_i,
   input wire logic [W-1:0] limit_i,
   // state
   output logic [W-1:0] cnt_o,
   output logic wrap_o
);

   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;

   // refuse widths the counter cannot serve
   if (W < 1) begin : g_bad_width
      $error("wdw_divider: width must be at least one");
   end

   // wrap on the terminal count, clear has priority
   always_comb begin
      wrap_o = run_i && (cnt_reg == limit_i) && !clr_i;
      cnt_next = cnt_reg;
      if (clr_i) begin
         cnt_next = '0;
      end else if (wrap_o) begin
         cnt_next = '0;
      end else if (run_i) begin
         cnt_next = cnt_reg + W'(1);
      end
   end

   // count register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign cnt_o = cnt_reg;

endmodule

// ---- sim/wdw_watchdog_asserts.sv ----
// port checker for the windowed watchdog
`timescale 1ns/1ps
module wdw_watchdog_chk import wdw_pkg::*; #(
   parameter int RC_DIV = RC_TICK_CYCLES
) (
   // clock and reset
   input wire logic CLOCK_I,
   input wire logic NRST_I,
   // inputs
   input wire wdw_cfg_t CFG_I,
   input wire wdw_evt_t EVT_I,
   input wire logic RCW_WR_I,
   input wire logic [RCW_W-1:0] RCW_WDATA_I,
   // outputs
   input wire logic [RCW_W-1:0] RCW_O,
   input wire logic RC_OSC_EN_O,
   input wire logic RUNNING_O,
   input wire logic WINDOW_OPEN_O,
   input wire logic WAKE_O,
   input wire logic WDOG_RESET_O
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!NRST_I);
   // kick taken while running and not parked in power save
   logic in_run;
   logic kick_ok;
   assign in_run = RUNNING_O && !RCW_O[RCW_SLEEP_BIT] && !RCW_O[RCW_IDLE_BIT];
   assign kick_ok = EVT_I.kick_instruction && in_run && WINDOW_OPEN_O;
   property p_osc_en;
      RC_OSC_EN_O == (CFG_I.hw_force_on_bit || RCW_O[RCW_SWEN_BIT]) && RUNNING_O == RC_OSC_EN_O;
   endproperty
   a_osc_en: assert property (p_osc_en) else $error("enable mismatch");
   property p_rst_pulse;
      WDOG_RESET_O |-> RCW_O[RCW_TIMEOUT_BIT] ##1 !WDOG_RESET_O;
   endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse bad");
   property p_wake;
      WAKE_O |-> !WDOG_RESET_O && (RCW_O[RCW_SLEEP_BIT] || RCW_O[RCW_IDLE_BIT]) ##1 !WAKE_O;
   endproperty
   a_wake: assert property (p_wake) else $error("wake pulse bad");
   property p_swen_clr;
      WDOG_RESET_O |-> ##2 !RCW_O[RCW_SWEN_BIT];
   endproperty
   a_swen_clr: assert property (p_swen_clr) else $error("sw enable kept");
   property p_flag_keep;
      $fell(RCW_O[RCW_TIMEOUT_BIT]) |-> $past(RCW_WR_I) && !$past(RCW_WDATA_I[RCW_TIMEOUT_BIT]);
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("flag lost");
   property p_sleep_keep;
      $fell(RCW_O[RCW_SLEEP_BIT]) |-> $past(RCW_WR_I) && !$past(RCW_WDATA_I[RCW_SLEEP_BIT]);
   endproperty
   a_sleep_keep: assert property (p_sleep_keep) else $error("sleep bit lost");
   property p_sleep_set;
      $rose(RCW_O[RCW_SLEEP_BIT]) |-> $past(EVT_I.enter_sleep);
   endproperty
   a_sleep_set: assert property (p_sleep_set) else $error("sleep bit cause");
   property p_window_disable_bit;
      CFG_I.window_disable_bit |-> WINDOW_OPEN_O;
   endproperty
   a_window_disable_bit: assert property (p_window_disable_bit) else $error("window shut");
   property p_early;
      EVT_I.kick_instruction && in_run && !WINDOW_OPEN_O |=> WDOG_RESET_O;
   endproperty
   a_early: assert property (p_early) else $error("early kick missed");
   property p_kick;
      kick_ok |-> ##2 !WDOG_RESET_O [*8];
   endproperty
   a_kick: assert property (p_kick) else $error("kick not cleared");
   property p_win_shut;
      kick_ok && !CFG_I.window_disable_bit |=> !WINDOW_OPEN_O;
   endproperty
   a_win_shut: assert property (p_win_shut) else $error("window open");
endmodule

bind wdw_watchdog wdw_watchdog_chk #(.RC_DIV(RC_DIV)) wdw_watchdog_chk_i (
   .CLOCK_I(CLOCK_I), .NRST_I(NRST_I), .CFG_I(CFG_I), .EVT_I(EVT_I), .RCW_WR_I(RCW_WR_I),
   .RCW_WDATA_I(RCW_WDATA_I), .RCW_O(RCW_O), .RC_OSC_EN_O(RC_OSC_EN_O),
   .RUNNING_O(RUNNING_O), .WINDOW_OPEN_O(WINDOW_OPEN_O), .WAKE_O(WAKE_O),
   .WDOG_RESET_O(WDOG_RESET_O));

// ---- sim/wdw_watchdog_tb.sv ----
// self-checking bench for the windowed watchdog
`timescale 1ns/1ps
module wdw_watchdog_tb import wdw_pkg::*;;
   localparam int RCD = 4;
   localparam int NB = RCD * PRE_DIV_SHORT;
   localparam wdw_evt_t KICK = 5'h10;
   localparam wdw_evt_t WAK = 5'h02;
   localparam wdw_evt_t CSW = 5'h01;
   logic CLOCK_I = 1'b0;
   logic NRST_I = 1'b0;
   wdw_cfg_t CFG_I;
   wdw_evt_t EVT_I;
   logic RCW_WR_I;
   logic [RCW_W-1:0] RCW_WDATA_I;
   logic [RCW_W-1:0] RCW_O;
   logic RC_OSC_EN_O;
   logic RUNNING_O;
   logic WINDOW_OPEN_O;
   logic WAKE_O;
   logic WDOG_RESET_O;
   int n_errors = 0;
   int comparisons = 0;
   logic [7:0] cfgs [4] = '{8'hC0, 8'hD0, 8'hC1, 8'hC7};
   int exps [4] = '{NB, RCD * PRE_DIV_LONG, 2 * NB, 128 * NB};
   wdw_evt_t pse [2] = '{5'h08, 5'h04};
   logic [7:0] pbit [2] = '{8'h08, 8'h04};

   wdw_watchdog #(.RC_DIV(RCD)) wdw_watchdog_i (
      .CLOCK_I(CLOCK_I), .NRST_I(NRST_I), .CFG_I(CFG_I), .EVT_I(EVT_I),
      .RCW_WR_I(RCW_WR_I), .RCW_WDATA_I(RCW_WDATA_I), .RCW_O(RCW_O),
      .RC_OSC_EN_O(RC_OSC_EN_O), .RUNNING_O(RUNNING_O), .WINDOW_OPEN_O(WINDOW_OPEN_O),
      .WAKE_O(WAKE_O), .WDOG_RESET_O(WDOG_RESET_O));

   // 50 MHz clock
   always #(CLK_PERIOD_NS / 2) CLOCK_I = ~CLOCK_I;

   // bus-side helpers
   task automatic step();
      @(posedge CLOCK_I);
      #2;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] d);
      RCW_WDATA_I = d;
      RCW_WR_I = 1'b1;
      step();
      RCW_WR_I = 1'b0;
   endtask
   task automatic pulse(input wdw_evt_t e);
      EVT_I = e;
      step();
      EVT_I = '0;
   endtask
   // time from an event to the next wake or reset pulse
   task automatic measure(input wdw_evt_t e, input int exp_n);
      int n;
      n = 0;
      pulse(e);
      while (WAKE_O !== 1'b1 && WDOG_RESET_O !== 1'b1 && n < 20000) begin
         step();
         n++;
      end
      comparisons++;
      if (n < exp_n - 3 || n > exp_n + 3) begin
         n_errors++;
         $display("[FAIL] %0t fired after %0d cycles, expected %0d", $time, n, exp_n);
      end
   endtask
   task automatic results();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // hang guard
   initial begin
      #(40000 * CLK_PERIOD_NS);
      n_errors++;
      results();
   end

   // main sequence
   initial begin
      int hits;
      CFG_I = 8'h40;
      EVT_I = '0;
      RCW_WR_I = 1'b0;
      RCW_WDATA_I = '0;
      repeat (5) @(posedge CLOCK_I);
      #2 NRST_I = 1'b1;
      chk(RCW_O, RCW_RESET);
      chk(8'(RUNNING_O), 8'h00);
      wr(8'h20);
      chk(8'(RC_OSC_EN_O), 8'h01);
      measure(KICK, NB);
      chk(RCW_O, 8'h30);
      repeat (20) step();
      chk(RCW_O, 8'h10);
      wr(8'h00);
      chk(RCW_O, 8'h00);
      for (int i = 0; i < 4; i++) begin
         CFG_I = cfgs[i];
         measure(KICK, exps[i]);
      end
      CFG_I = 8'hC0;
      chk(8'(RUNNING_O), 8'h01);
      hits = 0;
      repeat (5) begin
         pulse(KICK);
         repeat (100) begin
            step();
            if (WDOG_RESET_O === 1'b1) hits++;
         end
      end
      chk(8'(hits), 8'h00);
      pulse(KICK);
      repeat (100) step();
      measure(CSW, NB);
      for (int i = 0; i < 2; i++) begin
         pulse(KICK);
         repeat (60) step();
         measure(pse[i], NB);
         chk(8'(WAKE_O), 8'h01);
         chk(RCW_O & pbit[i], pbit[i]);
         wr(8'h00);
         pulse(pse[i]);
         repeat (60) step();
         wr(8'h00);
         measure(WAK, NB);
         chk(8'(WDOG_RESET_O), 8'h01);
      end
      step(); // let the reset pulse end before window mode
      CFG_I = 8'h82;
      pulse(KICK);
      repeat (50) step();
      chk(8'(WINDOW_OPEN_O), 8'h00);
      measure(KICK, 0);
      repeat (450) step();
      chk(8'(WINDOW_OPEN_O), 8'h01);
      measure(KICK, 4 * NB);
      results();
   end
endmodule
